// file: core/clockgen_i2c_slave_port.sv
`timescale 1ns/100ps
`default_nettype none
module clockgen_i2c_slave_port
   import clockgen_i2c_pkg::*;
(
   input  wire logic                     pclk,                     // APB clock, 20 MHz
   input  wire logic                     presetn,                  // Async reset, active low
   input  wire logic [7:0]               paddr,                    // APB byte address
   input  wire logic                     psel,                     // APB select
   input  wire logic                     penable,                  // APB access phase
   input  wire logic                     pwrite,                   // APB direction
   input  wire logic [31:0]              pwdata,                   // APB write data
   output var  logic [31:0]              prdata,                   // APB read data
   output var  logic                     pready,                   // APB ready
   output var  logic                     pslverr,                  // APB error, unmapped
   input  wire logic                     scl_clk,                  // Serial clock as clock
   input  wire logic                     scl_in,                   // Serial clock as level
   input  wire logic                     sda_in,                   // Data line level
   output var  logic                     sda_out,                  // Data drive value
   output var  logic                     sda_oe,                   // Data drive enable
   input  wire logic                     input_a_enable_pin,       // Input A enable pin
   input  wire logic                     input_b_enable_pin,       // Input B enable pin
   input  wire clockgen_i2c_pkg::strap_t address_strap_first,      // First address strap
   input  wire clockgen_i2c_pkg::strap_t address_strap_second,     // Second address strap
   output var  logic                     reference_input_a_enable, // Input A enabled
   output var  logic                     reference_input_b_enable, // Input B enabled
   output var  logic                     spi_mode_select           // Serial-peripheral mode
);
   logic [7:0]  regs [NUM_REGS];
   pins_t       pins_raw;
   pins_t       pins;
   logic        link_bit;
   logic        link_tog;
   logic        tog_s;
   logic        tog_prev;
   logic        bit_evt;
   logic        scl_prev;
   logic        sda_prev;
   logic        start_evt;
   logic        stop_evt;
   logic        fall_evt;
   logic [1:0]  settle;
   logic [6:0]  my_addr;
   logic [6:0]  dec_addr;
   logic        dec_spi;
   logic        port_on;
   port_state_t state;
   logic [3:0]  cnt;
   logic [6:0]  shift;
   logic [7:0]  in_byte;
   logic        ack_flag;
   logic        rw;
   logic [3:0]  ptr;
   logic [7:0]  tx;
   logic        i2c_we;
   logic [1:0]  in_en_field;
   logic        apb_setup;
   logic        apb_write;
   logic [3:0]  apb_index;
   logic        apb_is_reg;

   // Read a register or the filler past the end of the map
   function automatic logic [7:0] reg_read(input logic [3:0] idx, input logic [7:0] val);
      reg_read = (idx <= LAST_MAP_REGISTER) ? val : IDLE_READ_BYTE;
   endfunction

   // Register count must match the map, checked at elaboration
   if (NUM_REGS != int'(LAST_MAP_REGISTER) + 1) begin : g_regs_check
      $error("Register count mismatch");
   end

   assign pins_raw = '{scl: scl_in, sda: sda_in, a_pin: input_a_enable_pin,
                       b_pin: input_b_enable_pin, strap_first: address_strap_first,
                       strap_second: address_strap_second};

   level_sync #(.WIDTH($bits(pins_t))) u_pin_sync (
      .clk     (pclk),
      .rst_n   (presetn),
      .async_d (pins_raw),
      .sync_q  (pins)
   );

   level_sync #(.WIDTH(1)) u_tog_sync (
      .clk     (pclk),
      .rst_n   (presetn),
      .async_d (link_tog),
      .sync_q  (tog_s)
   );

   strap_address_decode u_strap (
      .strap_first  (pins.strap_first),
      .strap_second (pins.strap_second),
      .slave_addr   (dec_addr),
      .spi_mode     (dec_spi)
   );

   // Link side: one bit per rising serial clock, handed over by toggle
   always_ff @(posedge scl_clk or negedge presetn) begin
      if (!presetn) begin
         link_bit <= 1'b1;
         link_tog <= 1'b0;
      end else begin
         link_bit <= sda_in;
         link_tog <= ~link_tog;
      end
   end

   // Line edge history for START, STOP and falling clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
         tog_prev <= 1'b0;
      end else begin
         scl_prev <= pins.scl;
         sda_prev <= pins.sda;
         tog_prev <= tog_s;
      end
   end

   assign start_evt = port_on && pins.scl && scl_prev && sda_prev && !pins.sda;
   assign stop_evt  = port_on && pins.scl && scl_prev && !sda_prev && pins.sda;
   assign fall_evt  = port_on && scl_prev && !pins.scl; // Masks the false fall after reset
   assign bit_evt   = tog_s ^ tog_prev;
   assign in_byte   = {shift, link_bit};

   // Straps are caught once the synchroniser has settled after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settle          <= 2'd0;
         my_addr         <= 7'h00;
         port_on         <= 1'b0;
         spi_mode_select <= 1'b0;
      end else if (settle != STRAP_SETTLE) begin
         settle <= settle + 2'd1;
         if (settle == STRAP_SETTLE - 2'd1) begin
            my_addr         <= dec_addr;
            spi_mode_select <= dec_spi;
            port_on         <= !dec_spi;
         end
      end
   end

   // Frame sequencer: bit count, state, pointer and outgoing byte
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state    <= st_idle;
         cnt      <= 4'd0;
         shift    <= 7'h00;
         ack_flag <= 1'b0;
         rw       <= 1'b0;
         ptr      <= 4'd0;
         tx       <= IDLE_READ_BYTE;
      end else if (start_evt) begin
         state    <= st_addr;
         cnt      <= 4'd0;
         ack_flag <= 1'b0;
      end else if (stop_evt) begin
         state    <= st_idle;
         cnt      <= 4'd0;
         ack_flag <= 1'b0;
      end else if (bit_evt && state != st_idle) begin
         cnt   <= (cnt == ACK_BIT) ? 4'd0 : cnt + 4'd1;
         shift <= in_byte[6:0];
         if (cnt == LAST_DATA_BIT) begin
            case (state)
               st_addr: begin
                  ack_flag <= (in_byte[7:1] == my_addr);
                  rw       <= in_byte[0];
                  tx       <= reg_read(ptr, regs[ptr % 4'(NUM_REGS)]);
               end
               st_reg: begin
                  ack_flag <= 1'b1;
                  ptr      <= in_byte[3:0];
               end
               st_wdata: begin
                  ack_flag <= 1'b1;
                  if (ptr <= LAST_MAP_REGISTER) ptr <= ptr + 4'd1;
               end
               default: ack_flag <= 1'b0;
            endcase
         end else if (cnt == ACK_BIT) begin
            ack_flag <= 1'b0;
            case (state)
               st_addr:  state <= !ack_flag ? st_skip : (rw ? st_rdata : st_reg);
               st_reg:   state <= st_wdata;
               st_rdata: begin
                  if (link_bit) begin
                     state <= st_skip;
                  end else begin
                     if (ptr <= LAST_MAP_REGISTER) ptr <= ptr + 4'd1;
                     tx <= reg_read(ptr + 4'd1, regs[4'(ptr + 4'd1) % 4'(NUM_REGS)]);
                  end
               end
               default: state <= state;
            endcase
         end
      end
   end

   assign i2c_we = bit_evt && !start_evt && !stop_evt && state == st_wdata
                   && cnt == LAST_DATA_BIT && ptr <= LAST_MAP_REGISTER;

   // Data line: open-drain low only, updated while the clock is low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sda_out <= 1'b0;
         sda_oe  <= 1'b0;
      end else begin
         sda_out <= 1'b0;
         if (start_evt || stop_evt || !port_on) begin
            sda_oe <= 1'b0;
         end else if (fall_evt) begin
            sda_oe <= (cnt == ACK_BIT && ack_flag)
                      || (state == st_rdata && cnt < ACK_BIT && !tx[3'(7 - cnt)]);
         end
      end
   end

   assign apb_setup  = psel && !penable;
   assign apb_write  = psel && penable && pready && pwrite;
   assign apb_index  = paddr[5:2];
   assign apb_is_reg = paddr[1:0] == 2'b00 && paddr[7:6] == 2'b00
                       && apb_index <= LAST_MAP_REGISTER;

   // Register store, written by the serial port and by APB
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NUM_REGS; i++) regs[i] <= REG_RESET;
      end else begin
         if (i2c_we) regs[ptr] <= in_byte;
         if (apb_write && apb_is_reg) regs[apb_index] <= pwdata[7:0];
      end
   end

   // APB slave: data and error prepared in setup, zero wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= 1'b1;
         if (apb_setup) begin
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (apb_is_reg) begin
               prdata[7:0] <= regs[apb_index];
            end else if (paddr == STATUS_OFFSET && !pwrite) begin
               prdata[10:0] <= {state != st_idle, spi_mode_select, ack_flag, my_addr, port_on};
            end else begin
               pslverr <= 1'b1;
            end
         end
      end
   end

   assign in_en_field = regs[CTRL_REG_INDEX][IN_EN_LSB +: 2];

   // Reference input enables from the field or the pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reference_input_a_enable <= 1'b0;
         reference_input_b_enable <= 1'b0;
      end else begin
         case (in_en_field)
            IN_EN_PINS: begin
               reference_input_a_enable <= pins.a_pin;
               reference_input_b_enable <= pins.b_pin;
            end
            IN_EN_A: begin
               reference_input_a_enable <= 1'b1;
               reference_input_b_enable <= 1'b0;
            end
            IN_EN_B: begin
               reference_input_a_enable <= 1'b0;
               reference_input_b_enable <= 1'b1;
            end
            default: begin
               reference_input_a_enable <= 1'b1;
               reference_input_b_enable <= 1'b1;
            end
         endcase
      end
   end

   // Checks on the port behaviour
   AST_ENABLE_MAP: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 reference_input_a_enable == ($past(in_en_field) == IN_EN_PINS ? $past(pins.a_pin)
                                       : $past(in_en_field[0])))
      else $error("Input A enable does not follow field and pin");
   AST_ENABLE_MAP_B: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 reference_input_b_enable == ($past(in_en_field) == IN_EN_PINS ? $past(pins.b_pin)
                                       : $past(in_en_field[1])))
      else $error("Input B enable does not follow field and pin");
   AST_SPI_SILENT: assert property (@(posedge pclk) disable iff (!presetn)
      spi_mode_select |-> !sda_oe && state == st_idle)
      else $error("Serial-peripheral mode but two-wire port active");
   AST_OPEN_DRAIN: assert property (@(posedge pclk) disable iff (!presetn)
      sda_oe |-> sda_out == 1'b0)
      else $error("Data line driven high");
   AST_START_FRAME: assert property (@(posedge pclk) disable iff (!presetn)
      start_evt |=> state == st_addr && cnt == 4'd0 && !sda_oe)
      else $error("START did not open an address phase");
   AST_STOP_RELEASE: assert property (@(posedge pclk) disable iff (!presetn)
      stop_evt |=> state == st_idle ##1 !sda_oe)
      else $error("STOP did not release the port");
   AST_BIT_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
      bit_evt && !start_evt && !stop_evt && state != st_idle
      |=> cnt == ($past(cnt) == ACK_BIT ? 4'd0 : $past(cnt) + 4'd1))
      else $error("Bit counter out of step");
   AST_DIRECTION: assert property (@(posedge pclk) disable iff (!presetn)
      bit_evt && !start_evt && !stop_evt && state == st_addr && cnt == LAST_DATA_BIT
      |=> rw == $past(link_bit))
      else $error("Direction bit not taken from eighth bit");
   AST_ADDR_MATCH: assert property (@(posedge pclk) disable iff (!presetn)
      bit_evt && !start_evt && !stop_evt && state == st_addr && cnt == LAST_DATA_BIT
      |=> ack_flag == ($past(in_byte[7:1]) == my_addr) && my_addr[6:3] == ADDR_PREFIX)
      else $error("Address acknowledge does not match strapped address");
   AST_ADDR_NACK: assert property (@(posedge pclk) disable iff (!presetn)
      bit_evt && !start_evt && !stop_evt && state == st_addr && cnt == ACK_BIT && !ack_flag
      |=> state == st_skip)
      else $error("Unmatched address did not skip the transfer");
   AST_SKIP_SILENT: assert property (@(posedge pclk) disable iff (!presetn)
      state == st_skip |-> !sda_oe)
      else $error("Data line driven while transfer is ignored");
   AST_ACK_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
      fall_evt && port_on && !start_evt && !stop_evt && cnt == ACK_BIT && ack_flag |=> sda_oe)
      else $error("Acknowledge not driven low");
   AST_REG_POINTER: assert property (@(posedge pclk) disable iff (!presetn)
      bit_evt && !start_evt && !stop_evt && state == st_reg && cnt == LAST_DATA_BIT
      |=> ptr == $past(in_byte[3:0]))
      else $error("Register address byte not loaded into pointer");
   AST_WRITE_INC: assert property (@(posedge pclk) disable iff (!presetn)
      i2c_we |=> regs[$past(ptr)] == $past(in_byte) && ptr == $past(ptr) + 4'd1)
      else $error("Write byte not stored or pointer not advanced");
   AST_NACK_SKIP: assert property (@(posedge pclk) disable iff (!presetn)
      bit_evt && !start_evt && !stop_evt && state == st_rdata && cnt == ACK_BIT && link_bit
      |=> state == st_skip ##1 !sda_oe)
      else $error("Missing acknowledge did not end the read");
   AST_READ_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
      fall_evt && !start_evt && !stop_evt && state == st_rdata && cnt < ACK_BIT
      |=> sda_oe == !$past(tx[3'(7 - cnt)]))
      else $error("Read data bit not driven from outgoing byte");
endmodule
`default_nettype wire

// file: core/clockgen_i2c_pkg.sv
// Function
// - Input-enable field 00 lets the two enable pins enable inputs A and B; 01, 10, 11 enable only A, only B, or both.
// - Both address straps high select serial-peripheral mode; any other strap setting activates the two-wire port.
// - The clock line is input only; the data line is sampled as input and driven only open-drain low.
// - The slave address is 7 bits: fixed upper bits 1101 and three low bits chosen by two three-level straps.
// - START is data falling while clock is high, STOP is data rising while clock is high; both idle high.
// - After START each clock pulse carries one bit and any number of bytes may pass before STOP.
// - The first seven bits are the slave address and the eighth is the direction, low write, high read.
// - The ninth bit is the address acknowledge, driven low by the slave on success.
// - In a write the next byte is the register address, followed by its own acknowledge bit.
// - Each further write byte goes to the pointed register and the pointer then increments by one.
// - A read returns registers one after another from the pointed one through the last register.
package clockgen_i2c_pkg;

   // Register map
   localparam int         NUM_REGS          = 9;
   localparam logic [3:0] LAST_MAP_REGISTER = 4'h8;
   localparam logic [3:0] CTRL_REG_INDEX    = 4'h5;
   localparam int         IN_EN_LSB         = 2;
   localparam logic [7:0] REG_RESET         = 8'h00;
   localparam logic [7:0] STATUS_OFFSET     = 8'h24;
   localparam logic [7:0] IDLE_READ_BYTE    = 8'hff;

   // Slave address
   localparam logic [3:0] ADDR_PREFIX = 4'b1101;

   // Input-enable field codes
   localparam logic [1:0] IN_EN_PINS = 2'b00;
   localparam logic [1:0] IN_EN_A    = 2'b01;
   localparam logic [1:0] IN_EN_B    = 2'b10;
   localparam logic [1:0] IN_EN_BOTH = 2'b11;

   // Three-level strap codes
   localparam logic [1:0] STRAP_LOW  = 2'b00;
   localparam logic [1:0] STRAP_OPEN = 2'b01;
   localparam logic [1:0] STRAP_HIGH = 2'b10;

   // Bit positions within a byte frame, and strap settle cycles
   localparam logic [3:0] LAST_DATA_BIT = 4'd7;
   localparam logic [3:0] ACK_BIT       = 4'd8;
   localparam logic [1:0] STRAP_SETTLE  = 2'd3;

   typedef logic [1:0] strap_t;

   // Synchronised pin levels
   typedef struct packed {
      logic   scl;
      logic   sda;
      logic   a_pin;
      logic   b_pin;
      strap_t strap_first;
      strap_t strap_second;
   } pins_t;

   typedef enum logic [2:0] {
      st_idle,
      st_addr,
      st_reg,
      st_wdata,
      st_rdata,
      st_skip
   } port_state_t;

endpackage

// file: core/level_sync.sv
`timescale 1ns/100ps
`default_nettype none
module level_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,     // Destination clock
   input  wire logic             rst_n,   // Async reset, active low
   input  wire logic [WIDTH-1:0] async_d, // Levels from another domain
   output var  logic [WIDTH-1:0] sync_q   // Synchronised levels
);
   logic [WIDTH-1:0] meta;

   // Refuse an empty synchroniser at elaboration
   if (WIDTH < 1) begin : g_width_check
      $error("level_sync: WIDTH must be at least 1");
   end

   // Two-stage synchroniser; first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta   <= '0;
         sync_q <= '0;
      end else begin
         meta   <= async_d;
         sync_q <= meta;
      end
   end
endmodule
`default_nettype wire

// file: core/strap_address_decode.sv
`timescale 1ns/100ps
`default_nettype none
module strap_address_decode
   import clockgen_i2c_pkg::*;
(
   input  wire clockgen_i2c_pkg::strap_t strap_first,  // First address strap level
   input  wire clockgen_i2c_pkg::strap_t strap_second, // Second address strap level
   output var  logic [6:0]               slave_addr,   // Strapped slave address
   output var  logic                     spi_mode      // Serial-peripheral mode select
);
   // Map a three-level code to 0, 1, 2; unknown codes read as open
   function automatic logic [3:0] level(input strap_t s);
      case (s)
         STRAP_LOW:  level = 4'd0;
         STRAP_HIGH: level = 4'd2;
         default:    level = 4'd1;
      endcase
   endfunction

   logic [3:0] index;

   // Low address bits count through the strap combinations
   always_comb begin
      index      = 4'(level(strap_first) * 4'd3 + level(strap_second));
      slave_addr = {ADDR_PREFIX, index[2:0]};
      spi_mode   = (index == 4'd8);
   end
endmodule
`default_nettype wire

// file: bench/i2c_master_model.sv
`timescale 1ns/100ps
`default_nettype none
// Two-wire bus master; each phase lasts seven 48 ns link periods
module i2c_master_model (
   output var  logic scl,      // Serial clock, still between frames
   output var  logic sda_pull, // High while pulling data low
   input  wire logic sda       // Resolved data line
);
   localparam int PH = 336;
   // Bus idles high
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   // START, also a repeated one from clock low
   task automatic start();
      sda_pull = 1'b0;
      #PH scl = 1'b1;
      #PH sda_pull = 1'b1;
      #PH scl = 1'b0;
      #(PH/2);
   endtask
   // STOP, bus left free
   task automatic stop();
      sda_pull = 1'b1;
      #PH scl = 1'b1;
      #PH sda_pull = 1'b0;
      #PH;
   endtask
   // One bit per clock pulse; data moves only while clock is low
   task automatic bitx(input logic b, output logic r);
      sda_pull = ~b;
      #PH scl = 1'b1;
      #PH r = sda;
      scl = 1'b0;
      #(PH/2);
   endtask
   // Byte MSB first, then the ninth bit; ak high leaves it unacknowledged
   task automatic xbyte(input logic [7:0] d, input logic ak, output logic [7:0] q,
                        output logic r);
      for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
      bitx(ak, r);
   endtask
endmodule
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   import clockgen_i2c_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pa_pin, pb_pin, sda_out, sda_oe, scl, mpull;
   logic pready, pslverr, ena_a, ena_b, spi, e, r;
   logic [7:0] paddr, b, p;
   logic [6:0] adr;
   logic [31:0] pwdata, prdata, q;
   logic [7:0] mem [9];
   strap_t s1, s2;
   int mismatches, compares, seed, n, k;
   // Pull-up unless a party pulls low
   wire logic sda = ~(mpull | (sda_oe & ~sda_out));
   clockgen_i2c_slave_port DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .scl_clk(scl), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .input_a_enable_pin(pa_pin), .input_b_enable_pin(pb_pin),
      .address_strap_first(s1), .address_strap_second(s2), .reference_input_a_enable(ena_a),
      .reference_input_b_enable(ena_b), .spi_mode_select(spi));
   i2c_master_model m (.scl(scl), .sda_pull(mpull), .sda(sda));
   // 20 MHz clock
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // Expected address from the straps
   function automatic logic [6:0] exp_addr(strap_t f, strap_t s);
      return {ADDR_PREFIX, 3'(f * 3 + s)};
   endfunction
   // Expected enables {b, a}
   function automatic logic [1:0] exp_en(logic [1:0] fld, logic a, logic bb);
      return (fld == IN_EN_PINS) ? {bb, a} : fld;
   endfunction
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      compares++;
      if (g !== x) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
      int t;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 20);
      if (pready !== 1'b1) begin
         mismatches++;
         conclude();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic do_reset(input strap_t f, input strap_t s);
      @(posedge pclk);
      presetn <= 1'b0;
      s1 <= f;
      s2 <= s;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (10) @(posedge pclk);
   endtask
   task automatic check_regs();
      for (int i = 0; i < 9; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0, q, e);
         chk("register", 32'(mem[i]), q);
      end
   endtask
   // Pointer then data bytes, one past the last register
   task automatic i2c_write(input logic [7:0] pp);
      logic [7:0] d;
      m.start();
      m.xbyte({adr, 1'b0}, 1'b1, b, r);
      chk("address ack", 32'h0, 32'(r));
      m.xbyte(pp, 1'b1, b, r);
      chk("pointer ack", 32'h0, 32'(r));
      for (int i = pp; i <= 9; i++) begin
         d = 8'($random(seed));
         if (i <= 8) mem[i] = d;
         m.xbyte(d, 1'b1, b, r);
         chk("data ack", 32'h0, 32'(r));
      end
      m.stop();
   endtask
   // Read from pp through the last register, last byte unacknowledged
   task automatic i2c_read(input logic [7:0] pp);
      m.start();
      m.xbyte({adr, 1'b0}, 1'b1, b, r);
      m.xbyte(pp, 1'b1, b, r);
      m.start();
      m.xbyte({adr, 1'b1}, 1'b1, b, r);
      chk("read ack", 32'h0, 32'(r));
      for (int i = pp; i <= 8; i++) begin
         m.xbyte(8'hff, 1'(i == 8), b, r);
         chk("read byte", 32'(mem[i]), 32'(b));
      end
      m.stop();
      chk("line released", 32'h1, 32'(sda));
   endtask
   // Data is only ever pulled low
   always @(posedge pclk) if (sda_oe === 1'b1) chk("drive", 32'h0, 32'(sda_out));
   initial begin
      seed = 99913;
      {presetn, psel, penable, pwrite, pa_pin, pb_pin, s1, s2} = '0;
      {paddr, pwdata} = '0;
      for (k = 0; k < 9; k++) begin
         do_reset(strap_t'(k / 3), strap_t'(k % 3));
         chk("spi mode", 32'(k == 8), 32'(spi));
         apb(1'b0, STATUS_OFFSET, 32'h0, q, e);
         if (k < 8) chk("status address", 32'(exp_addr(s1, s2)), 32'(q[7:1]));
         adr = {ADDR_PREFIX, 3'(k * 5)}; // Mix matching and foreign addresses
         m.start();
         m.xbyte({adr, 1'b0}, 1'b1, b, r);
         chk("strap ack", 32'(k == 8 || adr != exp_addr(s1, s2)), 32'(r));
         m.stop();
      end
      $display("strap test done");
      k = $random(seed) & 7;
      do_reset(strap_t'(k / 3), strap_t'(k % 3));
      adr = exp_addr(s1, s2);
      for (int i = 0; i < 9; i++) mem[i] = REG_RESET;
      check_regs();
      apb(1'b0, 8'h28, 32'h0, q, e);
      chk("unmapped error", 32'h1, 32'(e));
      p = 8'($random(seed) & 7);
      i2c_write(p);
      check_regs();
      i2c_read(8'($random(seed) & 7));
      $display("write and read test done");
      for (int i = 0; i < 9; i++) begin
         mem[i] = 8'($random(seed));
         apb(1'b1, 8'(4 * i), 32'(mem[i]), q, e);
      end
      i2c_read(8'h00);
      m.start();
      m.xbyte({adr ^ 7'h01, 1'b0}, 1'b1, b, r);
      chk("foreign ack", 32'h1, 32'(r));
      m.xbyte(8'h02, 1'b1, b, r);
      m.xbyte(8'h5a, 1'b1, b, r);
      m.stop();
      check_regs();
      $display("bus test done");
      for (k = 0; k < 16; k++) begin
         apb(1'b1, 8'(4 * CTRL_REG_INDEX), 32'(k[3:2]) << IN_EN_LSB, q, e);
         pa_pin <= k[0];
         pb_pin <= k[1];
         n = 0;
         do begin
            @(posedge pclk);
            n++;
         end while ({ena_b, ena_a} !== exp_en(k[3:2], k[0], k[1]) && n < 10);
         chk("enables", 32'(exp_en(k[3:2], k[0], k[1])), 32'({ena_b, ena_a}));
      end
      $display("enable test done");
      conclude();
   end
   // Hang guard
   initial begin
      #3_000_000;
      mismatches++;
      conclude();
   end
endmodule
`default_nettype wire
